// file: design/cpu_programmer_registers.sv
`timescale 1ns/1ps
// How it works
// - Eight-bit accumulator holds operands and results.
// - Index register is high and low byte.
// - Stack pointer resets to 00FF.
// - Reset-stack instruction sets low byte ones.
// - Push decrements, pull increments stack pointer.
// - Stack offset modes use pointer as base.
// - Program counter increments or loads targets.
// - Reset loads counter from vector FFFE/FFFF.
// - Condition codes: mask, five flags, bits ones.
// - Overflow flag set on signed overflow.
// - Half-carry from bit three on adds.
// - Decimal adjust uses half-carry and carry.
// - Mask set blocks maskable interrupts.
// - Stack registers, set mask, then vector.
// - Interrupt stacking skips index high byte.
// - Highest-priority pending request served first.
// - Return restores registers and mask from stack.
// - Reset sets mask; clear instruction or return clears.
// - Negative flag follows result bit seven.
// - Zero flag set for zero result.
// - Carry on add carry, borrow, shifts.
// - Registers are not memory mapped.
module cpu_programmer_registers (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic srst_i,
	// Register writes and ALU requests.
	input wire cpu_regs_pkg::reg_write_t wr_i,
	input wire cpu_regs_pkg::alu_req_t alu_i,
	input wire logic shift_carry_i,
	input wire logic bit_test_carry_i,
	input wire logic bit_test_i,
	// Stack and program counter controls.
	input wire logic push_i,
	input wire logic pull_i,
	input wire logic reset_stack_instr_i,
	input wire logic [15:0] stack_offset_i,
	input wire cpu_regs_pkg::pc_op_t pc_op_i,
	input wire logic [15:0] pc_target_i,
	// Interrupt and mask controls.
	input wire logic [7:0] irq_req_i,
	input wire logic irq_stacked_i,
	input wire logic clear_mask_instr_i,
	input wire logic return_from_interrupt_instr_i,
	input wire logic [7:0] pulled_cc_i,
	input wire logic [7:0] vec_data_i,
	// Register views.
	output logic [7:0] acc_o,
	output logic [15:0] index_o,
	output logic [15:0] stack_pointer_reg_o,
	output logic [15:0] stack_addr_o,
	output logic [15:0] program_counter_reg_o,
	output logic [7:0] condition_code_reg_o,
	output logic [7:0] decimal_adjust_o,
	// Interrupt and vector fetch handshake.
	output logic irq_take_o,
	output logic [2:0] irq_num_o,
	output logic vec_rd_o,
	output logic [15:0] vec_addr_o,
	output logic running_o
);
	import cpu_regs_pkg::*;

	// ****************************************************************
	// State. These registers sit outside any memory decoder.
	// ****************************************************************
	logic [7:0] acc, next_acc; // Accumulator.
	logic [7:0] idx_hi, next_idx_hi; // Index high byte.
	logic [7:0] idx_lo, next_idx_lo; // Index low byte.
	logic [15:0] sp, next_sp; // Stack pointer.
	logic [15:0] pc, next_pc; // Program counter.
	logic [7:0] cc, next_cc; // Condition codes.
	seq_state_t state, next_state; // Sequencer.
	logic [7:0] alu_res; // Result of the current ALU operation.
	logic alu_carry; // Carry or borrow out of bit seven.
	logic alu_half; // Carry from bit three into four.
	logic alu_ovf; // Two's complement overflow.
	logic irq_pending; // Some request is asserted.
	logic [2:0] irq_pick; // Highest-priority request.

	// Picks the highest-priority request; bit 0 wins.
	function automatic logic [2:0] prio(input logic [7:0] r);
		logic [2:0] n;
		n = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (r[i]) begin
				n = 3'(i);
			end
		end
		return n;
	endfunction

	// ****************************************************************
	// Arithmetic flag calculation.
	// ****************************************************************
	// The ninth bit is kept so carry and borrow come from one adder.
	always_comb begin
		logic [8:0] sum;
		logic [4:0] low;
		logic cin;
		sum = 9'h000;
		low = 5'h00;
		cin = (alu_i.op == ALU_ADC) ? cc[CC_C] : 1'b0;
		alu_res = alu_i.opa;
		alu_carry = cc[CC_C];
		alu_half = cc[CC_H];
		alu_ovf = cc[CC_V];
		case (alu_i.op)
			ALU_ADD, ALU_ADC: begin
				sum = {1'b0, alu_i.opa} + {1'b0, alu_i.opb} + {8'h00, cin};
				low = {1'b0, alu_i.opa[3:0]} + {1'b0, alu_i.opb[3:0]} +
					{4'h0, cin};
				alu_res = sum[7:0];
				alu_carry = sum[8];
				alu_half = low[4];
				alu_ovf = (alu_i.opa[7] == alu_i.opb[7]) &&
					(sum[7] != alu_i.opa[7]);
			end
			ALU_SUB: begin
				sum = {1'b0, alu_i.opa} - {1'b0, alu_i.opb};
				alu_res = sum[7:0];
				alu_carry = sum[8]; // Borrow.
				alu_ovf = (alu_i.opa[7] != alu_i.opb[7]) &&
					(sum[7] != alu_i.opa[7]);
			end
			ALU_LOGIC: begin
				alu_res = alu_i.opb;
				alu_ovf = 1'b0;
			end
			ALU_SHIFT: begin
				alu_res = alu_i.opb;
				alu_carry = shift_carry_i;
				alu_ovf = alu_i.opb[7] ^ shift_carry_i;
			end
			default: begin
				alu_res = alu_i.opa;
			end
		endcase
	end

	// Decimal adjust picks its correction from H, C and the nibbles.
	always_comb begin
		decimal_adjust_o = ZERO_BYTE;
		if (cc[CC_H] || acc[3:0] > 4'h9) begin
			decimal_adjust_o[3:0] = 4'h6;
		end
		if (cc[CC_C] || acc > 8'h99) begin
			decimal_adjust_o[7:4] = 4'h6;
		end
	end

	// ****************************************************************
	// Interrupt selection. Masked requests are never taken.
	// ****************************************************************
	assign irq_pending = |irq_req_i;
	assign irq_pick = prio(irq_req_i);

	// ****************************************************************
	// Next-state logic for all programmer registers.
	// ****************************************************************
	always_comb begin
		next_acc = acc;
		next_idx_hi = idx_hi;
		next_idx_lo = idx_lo;
		next_sp = sp;
		next_pc = pc;
		next_cc = cc;
		next_state = state;
		if (wr_i.acc_we) begin
			next_acc = wr_i.data;
		end else if (alu_i.op != ALU_NONE) begin
			next_acc = alu_res;
		end
		if (wr_i.idx_hi_we) begin
			next_idx_hi = wr_i.data;
		end
		if (wr_i.idx_lo_we) begin
			next_idx_lo = wr_i.data;
		end
		if (alu_i.op != ALU_NONE) begin
			next_cc[CC_N] = alu_res[7];
			next_cc[CC_Z] = (alu_res == ZERO_BYTE);
			next_cc[CC_V] = alu_ovf;
			next_cc[CC_C] = alu_carry;
			next_cc[CC_H] = alu_half;
		end
		if (bit_test_i) begin
			next_cc[CC_C] = bit_test_carry_i;
		end
		// Writes win over push and pull; the instruction owns the pointer.
		if (wr_i.sp_we) begin
			next_sp = wr_i.word;
		end else if (reset_stack_instr_i) begin
			next_sp = {sp[15:8], STACK_LOW_ONES};
		end else if (push_i) begin
			next_sp = sp - 16'h0001;
		end else if (pull_i) begin
			next_sp = sp + 16'h0001;
		end
		case (pc_op_i)
			PC_INC: next_pc = pc + 16'h0001;
			PC_LOAD: next_pc = pc_target_i;
			default: next_pc = pc;
		endcase
		if (return_from_interrupt_instr_i) begin
			next_cc = pulled_cc_i;
		end else if (clear_mask_instr_i) begin
			next_cc[CC_I] = 1'b0;
		end
		case (state)
			ST_VEC_HI: begin
				next_pc = {vec_data_i, pc[7:0]};
				next_state = ST_VEC_LO;
			end
			ST_VEC_LO: begin
				next_pc = {pc[15:8], vec_data_i};
				next_state = ST_RUN;
			end
			ST_RUN: begin
				// Stacking (A, X, CC, PC; not H) is done first.
				if (irq_stacked_i) begin
					next_state = ST_IRQ_MASK;
				end
			end
			ST_IRQ_MASK: begin
				next_cc[CC_I] = 1'b1;
				next_state = ST_IRQ_VEC;
			end
			ST_IRQ_VEC: begin
				next_pc = {vec_data_i, pc[7:0]};
				next_state = ST_VEC_LO;
			end
			default: next_state = ST_VEC_HI;
		endcase
		next_cc = next_cc | CC_FIXED_ONES;
	end

	// ****************************************************************
	// Registers.
	// ****************************************************************
	// Reset sets the mask and presets the stack pointer.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			acc <= ZERO_BYTE;
			idx_hi <= ZERO_BYTE;
			idx_lo <= ZERO_BYTE;
			sp <= STACK_RESET;
			pc <= PC_RESET;
			cc <= CC_RESET;
			state <= ST_VEC_HI;
		end else begin
			acc <= next_acc;
			idx_hi <= next_idx_hi;
			idx_lo <= next_idx_lo;
			sp <= next_sp;
			pc <= next_pc;
			cc <= next_cc;
			state <= next_state;
		end
	end

	// ****************************************************************
	// Outputs.
	// ****************************************************************
	assign acc_o = acc;
	assign index_o = {idx_hi, idx_lo};
	assign stack_pointer_reg_o = sp;
	assign stack_addr_o = sp + stack_offset_i;
	assign program_counter_reg_o = pc;
	assign condition_code_reg_o = cc;
	assign irq_take_o = (state == ST_RUN) && irq_pending &&
		!cc[CC_I];
	assign irq_num_o = irq_pick;
	assign vec_rd_o = (state == ST_VEC_HI) || (state == ST_VEC_LO) ||
		(state == ST_IRQ_VEC);
	// Only the low vector byte sits at the odd address; the reset and the
	// interrupt high-byte fetches both show the even one, so the partner
	// can tell the two bytes of a vector apart.
	assign vec_addr_o = (state == ST_VEC_LO) ? RESET_VEC_LO_ADDR :
		RESET_VEC_HI_ADDR;
	assign running_o = (state == ST_RUN);

	// ****************************************************************
	// Checks.
	// ****************************************************************
	// Reset is checked one edge later, so no history from before the
	// first clock edge is needed.
	chk_stack_reset: assert property (@(posedge clk_i)
		srst_i |=> sp == STACK_RESET)
		else $error("stack pointer not preset");
	chk_stack_low: assert property (@(posedge clk_i)
		disable iff (srst_i)
		reset_stack_instr_i && !wr_i.sp_we |=>
		sp == {$past(sp[15:8]), STACK_LOW_ONES})
		else $error("reset stack wrong");
	chk_push_dec: assert property (@(posedge clk_i)
		disable iff (srst_i)
		push_i && !wr_i.sp_we && !reset_stack_instr_i |=>
		sp == $past(sp) - 16'h0001)
		else $error("push did not decrement");
	// The codes are unknown until the first reset edge has passed.
	chk_fixed_ones: assert property (@(posedge clk_i)
		disable iff (srst_i)
		cc[CC_FIX6] && cc[CC_FIX5])
		else $error("fixed bits not one");
	chk_mask_blocks: assert property (@(posedge clk_i)
		cc[CC_I] |-> !irq_take_o)
		else $error("masked interrupt taken");
	sequence irq_seq;
		state == ST_RUN && irq_stacked_i ##1 state == ST_IRQ_MASK;
	endsequence
	chk_irq_order: assert property (@(posedge clk_i)
		disable iff (srst_i)
		irq_seq |=> cc[CC_I] && vec_rd_o &&
		vec_addr_o == RESET_VEC_HI_ADDR)
		else $error("mask not set before vector");
	chk_zero_flag: assert property (@(posedge clk_i)
		disable iff (srst_i)
		alu_i.op != ALU_NONE && !return_from_interrupt_instr_i |=>
		cc[CC_Z] == ($past(alu_res) == ZERO_BYTE))
		else $error("zero flag wrong");
	chk_mask_reset: assert property (@(posedge clk_i)
		srst_i |=> cc[CC_I])
		else $error("mask clear after reset");
endmodule

// file: inc/cpu_regs_pkg.sv
package cpu_regs_pkg;

	// ****************************************************************
	// Widths and reset values.
	// ****************************************************************
	localparam int unsigned DATA_W = 8;
	localparam int unsigned ADDR_W = 16;
	localparam logic [15:0] STACK_RESET = 16'h00FF;
	localparam logic [7:0] STACK_LOW_ONES = 8'hFF;
	localparam logic [15:0] RESET_VEC_HI_ADDR = 16'hFFFE;
	localparam logic [15:0] RESET_VEC_LO_ADDR = 16'hFFFF;
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	// ****************************************************************
	// Condition code bit positions.
	// ****************************************************************
	localparam int unsigned CC_V = 7;
	localparam int unsigned CC_FIX6 = 6;
	localparam int unsigned CC_FIX5 = 5;
	localparam int unsigned CC_H = 4;
	localparam int unsigned CC_I = 3;
	localparam int unsigned CC_N = 2;
	localparam int unsigned CC_Z = 1;
	localparam int unsigned CC_C = 0;
	localparam logic [7:0] CC_RESET = 8'h68;
	localparam logic [7:0] CC_FIXED_ONES = 8'h60;

	// ****************************************************************
	// ALU operations; all but ALU_NONE update the flags.
	// ****************************************************************
	typedef enum logic [3:0] {
		ALU_NONE = 4'h0,
		ALU_ADD = 4'h1,
		ALU_ADC = 4'h2,
		ALU_SUB = 4'h3,
		ALU_LOGIC = 4'h4,
		ALU_SHIFT = 4'h5
	} alu_op_t;

	// Program counter source selection.
	typedef enum logic [1:0] {
		PC_HOLD = 2'h0,
		PC_INC = 2'h1,
		PC_LOAD = 2'h2
	} pc_op_t;

	// Controller sequence states, one-hot.
	typedef enum logic [4:0] {
		ST_VEC_HI = 5'h01,
		ST_VEC_LO = 5'h02,
		ST_RUN = 5'h04,
		ST_IRQ_MASK = 5'h08,
		ST_IRQ_VEC = 5'h10
	} seq_state_t;

	// Register write request from execution logic.
	typedef struct packed {
		logic acc_we;
		logic idx_hi_we;
		logic idx_lo_we;
		logic sp_we;
		logic [7:0] data;
		logic [15:0] word;
	} reg_write_t;

	// Flag update request from the ALU.
	typedef struct packed {
		alu_op_t op;
		logic [7:0] opa;
		logic [7:0] opb;
	} alu_req_t;

endpackage

// file: verification/exec_partner.sv
`timescale 1ns/1ps
// ****************************************************************
// Execution-side model: stacks on request, serves vector bytes.
// ****************************************************************
module exec_partner #(
	parameter int STACK_DELAY = 3,
	parameter logic [15:0] RST_VEC = 16'hC000,
	parameter logic [15:0] IRQ_VEC = 16'hE100
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic srst_i,
	// Requests from the block.
	input wire logic take_i,
	input wire logic vec_rd_i,
	input wire logic [15:0] vec_addr_i,
	// Answers to the block.
	output logic stacked_o,
	output logic [7:0] vec_data_o
);
	logic busy = 1'b0; // An interrupt entry is in progress.
	int cnt = 0; // Cycles left until stacking is done.
	logic [7:0] noise = 8'hA5; // Bus content while nothing is read.
	logic [15:0] vec;
	assign vec = busy ? IRQ_VEC : RST_VEC;
	// The bus is only valid while read, so a stale byte cannot pass.
	assign vec_data_o = !vec_rd_i ? noise :
		(vec_addr_i[0] ? vec[7:0] : vec[15:8]);
	// Stacking takes STACK_DELAY cycles and ends with one pulse.
	always_ff @(posedge clk_i) begin
		noise <= noise + 8'h5B;
		stacked_o <= 1'b0;
		if (srst_i) begin
			busy <= 1'b0;
			cnt <= 0;
		end else if (take_i && !busy) begin
			busy <= 1'b1;
			cnt <= STACK_DELAY;
		end else begin
			if (cnt != 0) cnt <= cnt - 1;
			if (cnt == 1) stacked_o <= 1'b1;
			if (busy && vec_rd_i && vec_addr_i[0]) busy <= 1'b0;
		end
	end
endmodule

// file: verification/tb.sv
`timescale 1ns/1ps
module tb;
	import cpu_regs_pkg::*;
	localparam logic [15:0] RV = 16'hC000;
	localparam logic [15:0] IV = 16'hE100;
	logic clk_i = 0, srst_i = 1;
	reg_write_t wr_i = '0;
	alu_req_t alu_i = '0;
	logic shift_carry_i = 0, bit_test_carry_i = 0, bit_test_i = 0;
	logic push_i = 0, pull_i = 0, reset_stack_instr_i = 0;
	logic [15:0] stack_offset_i = 16'h0000, pc_target_i = 16'h0000;
	pc_op_t pc_op_i = PC_HOLD;
	logic [7:0] irq_req_i = 8'h00, pulled_cc_i = 8'h00, vec_data_i;
	logic clear_mask_instr_i = 0, return_from_interrupt_instr_i = 0;
	logic irq_stacked_i, irq_take_o, vec_rd_o, running_o;
	logic [7:0] acc_o, condition_code_reg_o, decimal_adjust_o;
	logic [15:0] index_o, stack_pointer_reg_o, stack_addr_o;
	logic [15:0] program_counter_reg_o, vec_addr_o;
	logic [2:0] irq_num_o;
	int err_count = 0, n_compared = 0;

	cpu_programmer_registers dut (
		.clk_i(clk_i), .srst_i(srst_i), .wr_i(wr_i), .alu_i(alu_i),
		.shift_carry_i(shift_carry_i), .bit_test_carry_i(bit_test_carry_i),
		.bit_test_i(bit_test_i), .push_i(push_i), .pull_i(pull_i),
		.reset_stack_instr_i(reset_stack_instr_i),
		.stack_offset_i(stack_offset_i), .pc_op_i(pc_op_i),
		.pc_target_i(pc_target_i), .irq_req_i(irq_req_i),
		.irq_stacked_i(irq_stacked_i),
		.clear_mask_instr_i(clear_mask_instr_i),
		.return_from_interrupt_instr_i(return_from_interrupt_instr_i),
		.pulled_cc_i(pulled_cc_i), .vec_data_i(vec_data_i),
		.acc_o(acc_o), .index_o(index_o),
		.stack_pointer_reg_o(stack_pointer_reg_o),
		.stack_addr_o(stack_addr_o),
		.program_counter_reg_o(program_counter_reg_o),
		.condition_code_reg_o(condition_code_reg_o),
		.decimal_adjust_o(decimal_adjust_o), .irq_take_o(irq_take_o),
		.irq_num_o(irq_num_o), .vec_rd_o(vec_rd_o),
		.vec_addr_o(vec_addr_o), .running_o(running_o));
	exec_partner #(.STACK_DELAY(3), .RST_VEC(RV), .IRQ_VEC(IV)) model (
		.clk_i(clk_i), .srst_i(srst_i), .take_i(irq_take_o),
		.vec_rd_i(vec_rd_o), .vec_addr_i(vec_addr_o),
		.stacked_o(irq_stacked_i), .vec_data_o(vec_data_i));

	initial forever #25 clk_i = ~clk_i;

	// ****************************************************************
	// Access tasks.
	// ****************************************************************
	task chk(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// Ends an operation: one edge with strobes up, then all released.
	task fin;
		@(posedge clk_i);
		wr_i <= '0;
		alu_i <= '0;
		{push_i, pull_i, reset_stack_instr_i, bit_test_i} <= 4'h0;
		{clear_mask_instr_i, return_from_interrupt_instr_i} <= 2'h0;
		pc_op_i <= PC_HOLD;
		#1;
	endtask
	// Bounded wait, so a stuck handshake is reported, not hung on.
	task automatic wait_hi(ref logic s);
		for (int i = 0; i < 40 && s !== 1'b1; i++) begin
			@(posedge clk_i);
			#1;
		end
		chk(s, 1);
	endtask
	task do_reset;
		@(posedge clk_i);
		srst_i <= 1;
		repeat (2) @(posedge clk_i);
		srst_i <= 0;
		#1;
		wait_hi(running_o);
	endtask
	task alu(input alu_op_t op, input logic [7:0] a, b, e, cc, m);
		@(posedge clk_i);
		alu_i <= '{op, a, b};
		fin;
		chk(acc_o, e);
		chk(condition_code_reg_o & m, cc);
	endtask
	task tally_and_finish;
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// ****************************************************************
	// Test sequence.
	// ****************************************************************
	initial begin
		do_reset;
		chk(stack_pointer_reg_o, 16'h00FF);
		chk(condition_code_reg_o, 8'h68);
		chk(program_counter_reg_o, RV);
		@(posedge clk_i);
		wr_i <= '{1'b1, 1'b1, 1'b0, 1'b0, 8'h3C, 16'h0000};
		shift_carry_i <= 1;
		fin;
		chk(acc_o, 8'h3C);
		@(posedge clk_i);
		wr_i <= '{1'b0, 1'b0, 1'b1, 1'b1, 8'hA7, 16'h1234};
		fin;
		chk(index_o, 16'h3CA7);
		@(posedge clk_i);
		reset_stack_instr_i <= 1;
		fin;
		chk(stack_pointer_reg_o, 16'h12FF);
		@(posedge clk_i);
		push_i <= 1;
		fin;
		chk(stack_pointer_reg_o, 16'h12FE);
		@(posedge clk_i);
		pull_i <= 1;
		stack_offset_i <= 16'h0010;
		@(posedge clk_i);
		fin;
		chk(stack_pointer_reg_o, 16'h1300);
		chk(stack_addr_o, 16'h1310);
		@(posedge clk_i);
		pc_op_i <= PC_LOAD;
		pc_target_i <= 16'hFFFF;
		fin;
		chk(program_counter_reg_o, 16'hFFFF);
		@(posedge clk_i);
		pc_op_i <= PC_INC;
		fin;
		chk(program_counter_reg_o, 16'h0000);
		alu(ALU_ADD, 8'h7F, 8'h01, 8'h80, 8'h94, 8'h97);
		alu(ALU_ADD, 8'hFF, 8'h01, 8'h00, 8'h13, 8'h97);
		alu(ALU_ADC, 8'h00, 8'h00, 8'h01, 8'h00, 8'h97);
		alu(ALU_SUB, 8'h00, 8'h01, 8'hFF, 8'h05, 8'h87);
		alu(ALU_SUB, 8'h80, 8'h01, 8'h7F, 8'h80, 8'h87);
		alu(ALU_LOGIC, 8'h55, 8'h00, 8'h00, 8'h02, 8'h06);
		alu(ALU_SHIFT, 8'h00, 8'h80, 8'h80, 8'h05, 8'h07);
		alu(ALU_ADD, 8'h99, 8'h99, 8'h32, 8'h11, 8'h13);
		chk(decimal_adjust_o, 8'h66);
		@(posedge clk_i);
		bit_test_i <= 1;
		fin;
		chk(condition_code_reg_o[0], 0);
		@(posedge clk_i);
		irq_req_i <= 8'h06;
		repeat (4) begin
			@(posedge clk_i);
			#1;
			chk(irq_take_o, 0);
		end
		@(posedge clk_i);
		clear_mask_instr_i <= 1;
		fin;
		wait_hi(irq_take_o);
		chk(irq_num_o, 3'h1);
		@(posedge clk_i);
		irq_req_i <= 8'h00;
		wait_hi(irq_stacked_i);
		chk(condition_code_reg_o[3], 0);
		wait_hi(vec_rd_o);
		chk(condition_code_reg_o[3], 1);
		chk(vec_addr_o, 16'hFFFE);
		wait_hi(running_o);
		chk(program_counter_reg_o, IV);
		chk(index_o, 16'h3CA7);
		@(posedge clk_i);
		return_from_interrupt_instr_i <= 1;
		pulled_cc_i <= 8'h01;
		fin;
		chk(condition_code_reg_o, 8'h61);
		do_reset;
		chk(stack_pointer_reg_o, 16'h00FF);
		chk(condition_code_reg_o, 8'h68);
		chk(program_counter_reg_o, RV);
		chk(acc_o, 8'h00);
		tally_and_finish;
	end

	// Watchdog well beyond the fewer than a hundred cycles the sequence needs.
	initial begin
		repeat (3000) @(posedge clk_i);
		err_count++;
		tally_and_finish;
	end
endmodule
